// File: rc_err_pkg.sv
// Shared constants and types for the remote command front end and its error queue
package rc_err_pkg;

  // ---------------------------------------------------------------------------
  // Bus map
  // ---------------------------------------------------------------------------
  localparam int          AVS_ADDR_W = 5;
  localparam int          AVS_DATA_W = 32;
  localparam logic [4:0]  ADDR_CMD   = 5'h00;
  localparam logic [4:0]  ADDR_MODE  = 5'h04;
  localparam logic [4:0]  ADDR_STATE = 5'h08;
  localparam logic [4:0]  ADDR_POP   = 5'h0c;
  localparam logic [4:0]  ADDR_COUNT = 5'h10;

  // State register fields
  localparam int STATE_OP_LSB  = 0;
  localparam int STATE_OUT_BIT = 2;
  localparam int STATE_ERR_BIT = 3;

  // ---------------------------------------------------------------------------
  // Operating state, command and mode types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_LOCAL   = 2'b00,
    ST_REMOTE  = 2'b01,
    ST_LOCKOUT = 2'b10
  } op_state_t;

  typedef enum logic [3:0] {
    OP_NOP           = 4'h0,
    OP_LOCAL         = 4'h1,
    OP_LOCKOUT       = 4'h2,
    OP_REMOTE        = 4'h3,
    OP_OUT_ACTIVATE  = 4'h4,
    OP_OUT_STANDBY   = 4'h5,
    OP_RANGE_HOLD    = 4'h6,
    OP_PROBE_KIND    = 4'h7,
    OP_CJ_SOURCE     = 4'h8,
    OP_SENSOR_SELECT = 4'h9,
    OP_TEMP_MEASURE  = 4'ha,
    OP_PRES_UNITS    = 4'hb,
    OP_PRES_FUNC     = 4'hc,
    OP_RTD_SOURCE    = 4'hd,
    OP_SELECT_PROBE  = 4'he,
    OP_SET_VALUE     = 4'hf
  } cmd_op_t;

  typedef struct packed {
    logic      header_unknown;
    logic      hold_on;
    logic      value_below;
    logic      value_above;
    logic      units_bad;
    logic [4:0] numeric_len;
    logic      nonnumeric;
    logic      param_valid;
    logic      param_present;
    cmd_op_t   op;
  } cmd_t;
  localparam int CMD_W = $bits(cmd_t);

  typedef struct packed {
    logic platinum_reference_probe_selected;
    logic rtd_source;
    logic volts_mode;
    logic tc_source;
    logic measure_mode;
  } mode_t;
  localparam int MODE_W = $bits(mode_t);

  // ---------------------------------------------------------------------------
  // Error codes and classes
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CLS_EXE = 2'b00,
    CLS_CME = 2'b01,
    CLS_QYE = 2'b10,
    CLS_DDE = 2'b11
  } err_class_t;

  typedef struct packed {
    err_class_t cls;
    logic [7:0] code;
  } err_entry_t;
  localparam int ENTRY_W = $bits(err_entry_t);

  localparam logic [4:0] NUMERIC_MAX_LEN = 5'h0a;
  localparam logic [7:0] ERR_NONE        = 8'h00;
  localparam logic [7:0] ERR_QUEUE_OVF   = 8'h01;
  localparam logic [7:0] ERR_OUT_MODE    = 8'h64;
  localparam logic [7:0] ERR_NON_NUMERIC = 8'h65;
  localparam logic [7:0] ERR_NUM_LONG    = 8'h66;
  localparam logic [7:0] ERR_UNITS       = 8'h67;
  localparam logic [7:0] ERR_PROBE_CLASH = 8'h68;
  localparam logic [7:0] ERR_ABOVE_RANGE = 8'h69;
  localparam logic [7:0] ERR_BELOW_RANGE = 8'h6a;
  localparam logic [7:0] ERR_MISSING_PAR = 8'h6c;
  localparam logic [7:0] ERR_TEMP_PUNITS = 8'h6d;
  localparam logic [7:0] ERR_HOLD_PARAM  = 8'h6e;
  localparam logic [7:0] ERR_HOLD_VOLTS  = 8'h6f;
  localparam logic [7:0] ERR_PROBE_KIND  = 8'h70;
  localparam logic [7:0] ERR_CJ_SOURCE   = 8'h71;
  localparam logic [7:0] ERR_SENSOR_SEL  = 8'h72;
  localparam logic [7:0] ERR_PRESSURE    = 8'h74;
  localparam logic [7:0] ERR_UNKNOWN_HDR = 8'h75;
  localparam logic [7:0] ERR_BAD_PARAM   = 8'h76;

  // Hardware fault sources, index = bit of hw_evt_t
  typedef struct packed {
    logic adc_fail;
    logic out_of_tol;
    logic overload;
    logic tx_overflow;
    logic cmdbuf_overflow;
    logic rx_overflow;
    logic zero_offset;
  } hw_evt_t;
  localparam int HW_N = $bits(hw_evt_t);

  localparam err_entry_t HW_TABLE [HW_N] = '{
    '{CLS_EXE, 8'h74}, '{CLS_EXE, 8'h78}, '{CLS_EXE, 8'h79}, '{CLS_QYE, 8'h7a},
    '{CLS_DDE, 8'h7b}, '{CLS_DDE, 8'h7c}, '{CLS_DDE, 8'h7d}
  };

endpackage : rc_err_pkg

// File: remote_command_error_queue.sv
// Remote command checker, operating-state control and last-in error queue
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Local command: local state, lockout cleared
// - Lockout command enters lockout state
// - Remote command enters remote state, except from lockout state
// - Pop query returns newest error, removes it
// - Output commands in measure/thermocouple mode: 100
// - Non-numeric character in numeric field: 101
// - Numeric field over ten characters: 102
// - Unknown units name or prefix: 103
// - Resistance source versus platinum probe clash: 104
// - Value above range 105, below 106
// - Missing required parameter: 108
// - Bad temperature or pressure units: 109
// - Bad hold/probe/junction/sensor parameter: 110, 112-114
// - Range hold on outside volts mode: 111
// - No pressure module or zero offset: 116
// - Unrecognised command header: 117
// - Otherwise invalid parameter: 118
// - Serial receive buffer overflow: 120
// - Command string buffer overflow: 121
// - Serial transmit buffer overflow: 122
// - Output overload: 123
// - Self-test fails: tolerance 124, converter 125
// - Empty queue answers pop with zero
module remote_command_error_queue
  import rc_err_pkg::*;
#(
  parameter int QUEUE_DEPTH = 16
) (
  // Clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_n,
  // Avalon-MM slave
  input  wire logic [AVS_ADDR_W-1:0] i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [AVS_DATA_W-1:0] i_avs_writedata,
  output logic      [AVS_DATA_W-1:0] o_avs_readdata,
  output logic                       o_avs_waitrequest,
  // Fault indications from the instrument
  input  wire hw_evt_t               i_hw_events,
  input  wire logic                  i_pressure_present,
  // Status
  output op_state_t                  o_op_state,
  output logic                       o_output_active,
  output logic                       o_error_pending
);

  localparam int              CNT_W   = $clog2(QUEUE_DEPTH + 1);
  localparam int              QI_W    = $clog2(QUEUE_DEPTH);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(QUEUE_DEPTH);
  localparam err_entry_t      OVF_ENTRY  = '{CLS_DDE, ERR_QUEUE_OVF};
  localparam err_entry_t      NONE_ENTRY = '{CLS_EXE, ERR_NONE};

  // ---------------------------------------------------------------------------
  // Avalon slave: one wait cycle per access
  // ---------------------------------------------------------------------------
  logic                  avs_req;
  logic                  rd_take;
  logic                  wr_done;
  cmd_t                  cmd_q;
  logic                  cmd_stb_q;
  mode_t                 mode_q;
  logic [CNT_W-1:0]      count_q;
  logic [CNT_W-1:0]      count_d;
  logic [QI_W-1:0]       top_idx;
  err_entry_t            mem [QUEUE_DEPTH];
  logic                  pop_req;

  assign avs_req = i_avs_read | i_avs_write;
  assign rd_take = i_avs_read & o_avs_waitrequest;
  assign wr_done = i_avs_write & ~o_avs_waitrequest;
  assign pop_req = rd_take && (i_avs_address == ADDR_POP);
  assign top_idx = QI_W'(count_q - CNT_ONE);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= ~(avs_req & o_avs_waitrequest);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_avs_readdata <= '0;
    end else if (rd_take) begin
      unique case (i_avs_address)
        ADDR_CMD:   o_avs_readdata <= AVS_DATA_W'(cmd_q);
        ADDR_MODE:  o_avs_readdata <= AVS_DATA_W'(mode_q);
        ADDR_STATE: begin
          o_avs_readdata <= '0;
          o_avs_readdata[STATE_OP_LSB +: 2] <= o_op_state;
          o_avs_readdata[STATE_OUT_BIT]     <= o_output_active;
          o_avs_readdata[STATE_ERR_BIT]     <= o_error_pending;
        end
        ADDR_POP: begin
          if (count_q == '0) begin
            o_avs_readdata <= AVS_DATA_W'(NONE_ENTRY);
          end else begin
            o_avs_readdata <= AVS_DATA_W'(mem[top_idx]);
          end
        end
        ADDR_COUNT: o_avs_readdata <= AVS_DATA_W'(count_q);
        default:    o_avs_readdata <= '0;
      endcase
    end
  end

  // Command and mode registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cmd_q     <= '0;
      cmd_stb_q <= 1'b0;
    end else begin
      cmd_stb_q <= wr_done && (i_avs_address == ADDR_CMD);
      if (wr_done && (i_avs_address == ADDR_CMD)) begin
        cmd_q <= i_avs_writedata[CMD_W-1:0];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      mode_q <= '0;
    end else if (wr_done && (i_avs_address == ADDR_MODE)) begin
      mode_q <= i_avs_writedata[MODE_W-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Command checking
  // ---------------------------------------------------------------------------
  logic       cmd_err_hit;
  err_entry_t cmd_err;
  logic       needs_param;

  always_comb begin
    cmd_err_hit = 1'b0;
    cmd_err     = NONE_ENTRY;
    needs_param = cmd_q.op inside {OP_RANGE_HOLD, OP_PROBE_KIND, OP_CJ_SOURCE,
                                   OP_SENSOR_SELECT, OP_TEMP_MEASURE, OP_PRES_UNITS,
                                   OP_SET_VALUE};
    if (cmd_q.header_unknown) begin
      cmd_err = '{CLS_CME, ERR_UNKNOWN_HDR};
    end else if (needs_param && !cmd_q.param_present) begin
      cmd_err = '{CLS_CME, ERR_MISSING_PAR};
    end else if (cmd_q.nonnumeric) begin
      cmd_err = '{CLS_CME, ERR_NON_NUMERIC};
    end else if (cmd_q.numeric_len > NUMERIC_MAX_LEN) begin
      cmd_err = '{CLS_EXE, ERR_NUM_LONG};
    end else if (cmd_q.units_bad) begin
      cmd_err = '{CLS_CME, ERR_UNITS};
    end else begin
      unique case (cmd_q.op)
        OP_OUT_ACTIVATE, OP_OUT_STANDBY: begin
          if (mode_q.measure_mode || mode_q.tc_source) begin
            cmd_err = '{CLS_EXE, ERR_OUT_MODE};
          end
        end
        OP_RANGE_HOLD: begin
          if (!cmd_q.param_valid) begin
            cmd_err = '{CLS_CME, ERR_HOLD_PARAM};
          end else if (cmd_q.hold_on && !mode_q.volts_mode) begin
            cmd_err = '{CLS_EXE, ERR_HOLD_VOLTS};
          end
        end
        OP_PROBE_KIND: begin
          if (!cmd_q.param_valid) cmd_err = '{CLS_CME, ERR_PROBE_KIND};
        end
        OP_CJ_SOURCE: begin
          if (!cmd_q.param_valid) cmd_err = '{CLS_CME, ERR_CJ_SOURCE};
        end
        OP_SENSOR_SELECT: begin
          if (!cmd_q.param_valid) cmd_err = '{CLS_CME, ERR_SENSOR_SEL};
        end
        OP_TEMP_MEASURE, OP_PRES_UNITS: begin
          if (!cmd_q.param_valid) cmd_err = '{CLS_CME, ERR_TEMP_PUNITS};
        end
        OP_PRES_FUNC: begin
          if (!i_pressure_present) cmd_err = '{CLS_EXE, ERR_PRESSURE};
        end
        OP_RTD_SOURCE: begin
          if (mode_q.platinum_reference_probe_selected) cmd_err = '{CLS_EXE, ERR_PROBE_CLASH};
        end
        OP_SELECT_PROBE: begin
          if (mode_q.rtd_source) cmd_err = '{CLS_EXE, ERR_PROBE_CLASH};
        end
        OP_SET_VALUE: begin
          if (cmd_q.value_above) begin
            cmd_err = '{CLS_EXE, ERR_ABOVE_RANGE};
          end else if (cmd_q.value_below) begin
            cmd_err = '{CLS_EXE, ERR_BELOW_RANGE};
          end else if (!cmd_q.param_valid) begin
            cmd_err = '{CLS_CME, ERR_BAD_PARAM};
          end
        end
        default: begin
          if (cmd_q.param_present && !cmd_q.param_valid) begin
            cmd_err = '{CLS_CME, ERR_BAD_PARAM};
          end
        end
      endcase
    end
    cmd_err_hit = cmd_stb_q && (cmd_err.code != ERR_NONE);
  end

  // ---------------------------------------------------------------------------
  // Operating state and output activity
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_op_state <= ST_LOCAL;
    end else if (cmd_stb_q && !cmd_q.header_unknown) begin
      unique case (cmd_q.op)
        OP_LOCAL:   o_op_state <= ST_LOCAL;
        OP_LOCKOUT: o_op_state <= ST_LOCKOUT;
        OP_REMOTE: begin
          if (o_op_state != ST_LOCKOUT) o_op_state <= ST_REMOTE;
        end
        default:    o_op_state <= o_op_state;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_output_active <= 1'b0;
    end else if (cmd_stb_q && !cmd_err_hit) begin
      if (cmd_q.op == OP_OUT_ACTIVATE) o_output_active <= 1'b1;
      if (cmd_q.op == OP_OUT_STANDBY)  o_output_active <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Hardware fault capture, drained one per cycle behind command errors
  // ---------------------------------------------------------------------------
  logic [HW_N-1:0] hw_vec;
  logic [HW_N-1:0] pend_q;
  logic [HW_N-1:0] hw_grant;
  err_entry_t      hw_entry;
  logic            push_valid;
  err_entry_t      push_entry;

  assign hw_vec   = i_hw_events;
  assign hw_grant = cmd_err_hit ? '0 : (pend_q & (~pend_q + HW_N'(1)));

  for (genvar g = 0; g < HW_N; g++) begin : g_pend
    // New fault wins over the clear of the same bit
    always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
        pend_q[g] <= 1'b0;
      end else begin
        pend_q[g] <= (pend_q[g] & ~hw_grant[g]) | hw_vec[g];
      end
    end
  end

  always_comb begin
    hw_entry = NONE_ENTRY;
    for (int i = 0; i < HW_N; i++) begin
      if (hw_grant[i]) hw_entry = HW_TABLE[i];
    end
  end

  assign push_valid = cmd_err_hit | (|hw_grant);
  assign push_entry = cmd_err_hit ? cmd_err : hw_entry;

  // ---------------------------------------------------------------------------
  // Error queue, newest entry on top
  // ---------------------------------------------------------------------------
  logic            mem_we;
  logic [QI_W-1:0] mem_wa;
  err_entry_t      mem_wd;

  always_comb begin
    count_d = count_q;
    mem_we  = 1'b0;
    mem_wa  = '0;
    mem_wd  = push_entry;
    if (push_valid && pop_req) begin
      mem_we = 1'b1;
      if (count_q == '0) begin
        count_d = CNT_ONE;
      end else begin
        mem_wa = top_idx;
      end
    end else if (push_valid) begin
      mem_we = 1'b1;
      if (count_q == CNT_MAX) begin
        mem_wa = top_idx;
        mem_wd = OVF_ENTRY;
      end else begin
        mem_wa  = count_q[QI_W-1:0];
        count_d = count_q + CNT_ONE;
      end
    end else if (pop_req && (count_q != '0)) begin
      count_d = count_q - CNT_ONE;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (mem_we) mem[mem_wa] <= mem_wd;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      count_q         <= '0;
      o_error_pending <= 1'b0;
    end else begin
      count_q         <= count_d;
      o_error_pending <= (count_d != '0);
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  a_local_clears_lock: assert property (
    cmd_stb_q && !cmd_q.header_unknown && cmd_q.op == OP_LOCAL |=> o_op_state == ST_LOCAL)
    else $error("local command did not reach local state");

  a_lockout_entry: assert property (
    cmd_stb_q && !cmd_q.header_unknown && cmd_q.op == OP_LOCKOUT |=> o_op_state == ST_LOCKOUT)
    else $error("lockout command did not reach lockout state");

  a_remote_entry: assert property (
    cmd_stb_q && !cmd_q.header_unknown && cmd_q.op == OP_REMOTE && o_op_state == ST_LOCAL
    |=> o_op_state == ST_REMOTE)
    else $error("remote command did not reach remote state");

  a_pop_newest: assert property (
    pop_req && !push_valid && count_q != '0
    |=> o_avs_readdata == AVS_DATA_W'($past(mem[top_idx])) && count_q == $past(count_q) - CNT_ONE
    && !o_avs_waitrequest)
    else $error("pop did not return and remove the newest entry");

  a_pop_empty_zero: assert property (
    pop_req && count_q == '0 && !push_valid |=> o_avs_readdata == '0 && count_q == '0)
    else $error("empty pop did not answer zero");

  a_full_overflow: assert property (
    push_valid && !pop_req && count_q == CNT_MAX
    |=> count_q == CNT_MAX && mem[top_idx] == OVF_ENTRY)
    else $error("full queue did not record overflow entry");

  a_out_mode_err: assert property (
    cmd_stb_q && cmd_q.op == OP_OUT_ACTIVATE && mode_q.measure_mode && !cmd_q.header_unknown
    && cmd_q.numeric_len <= NUMERIC_MAX_LEN && !cmd_q.nonnumeric && !cmd_q.units_bad
    |-> push_entry == err_entry_t'{CLS_EXE, ERR_OUT_MODE}
    ##1 (!o_output_active || $past(o_output_active)))
    else $error("output command in measure mode not logged");

  a_numeric_long: assert property (
    cmd_stb_q && !cmd_q.header_unknown && cmd_q.param_present && !cmd_q.nonnumeric
    && cmd_q.numeric_len > NUMERIC_MAX_LEN |-> push_valid && push_entry.code == ERR_NUM_LONG)
    else $error("overlong numeric field not logged");

  a_hold_volts: assert property (
    cmd_stb_q && cmd_q == cmd_t'{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 5'h00, 1'b0, 1'b1, 1'b1,
                                 OP_RANGE_HOLD} && !mode_q.volts_mode
    |-> push_entry == err_entry_t'{CLS_EXE, ERR_HOLD_VOLTS})
    else $error("range hold outside volts mode not logged");

  a_header_unknown: assert property (
    cmd_stb_q && cmd_q.header_unknown |-> push_entry == err_entry_t'{CLS_CME, ERR_UNKNOWN_HDR}
    ##1 o_op_state == $past(o_op_state))
    else $error("unknown header not logged or changed state");

  a_rx_ovf_held: assert property (
    i_hw_events.rx_overflow |=> pend_q[1] || (push_valid && push_entry.code != ERR_NONE))
    else $error("receive overflow lost");

  a_bus_answer: assert property (
    avs_req && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not after one wait cycle");

  c_pop_entry:   cover property (pop_req && count_q != '0);
  c_queue_full:  cover property (push_valid && count_q == CNT_MAX);
  c_lockout_rem: cover property (o_op_state == ST_LOCKOUT ##[1:20] o_op_state == ST_REMOTE);
  c_hw_vs_cmd:   cover property (cmd_err_hit && pend_q != '0);

endmodule : remote_command_error_queue

`default_nettype wire

// File: rc_host_model.sv
// Remote host model: Avalon-MM master that reaches the command block
`timescale 1ns/1ps
`default_nettype none

module rc_host_model
  import rc_err_pkg::*;
(
  // Clock
  input  wire logic                  i_ref_clk,
  // Slave answer
  input  wire logic [AVS_DATA_W-1:0] i_avs_readdata,
  input  wire logic                  i_avs_waitrequest,
  // Master request
  output var logic  [AVS_ADDR_W-1:0] o_avs_address,
  output var logic                   o_avs_read,
  output var logic                   o_avs_write,
  output var logic  [AVS_DATA_W-1:0] o_avs_writedata,
  output var logic                   o_stuck
);
  // ---------------------------------------------------------------------------
  // Bus access
  // ---------------------------------------------------------------------------
  initial begin
    o_avs_address = '0;
    o_avs_read = 1'b0;
    o_avs_write = 1'b0;
    o_avs_writedata = '0;
    o_stuck = 1'b0;
  end

  // Held until waitrequest is seen low at an edge, or for at most 20 edges
  task automatic access(input logic rd, input logic [AVS_ADDR_W-1:0] a,
                        input logic [AVS_DATA_W-1:0] d, output logic [AVS_DATA_W-1:0] q);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    o_avs_address <= a;
    o_avs_read <= rd;
    o_avs_write <= !rd;
    o_avs_writedata <= d;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (i_avs_waitrequest !== 1'b0 && n < 20);
    q = i_avs_readdata;
    if (i_avs_waitrequest !== 1'b0) o_stuck <= 1'b1;
    o_avs_read <= 1'b0;
    o_avs_write <= 1'b0;
    o_avs_address <= ~a;
    o_avs_writedata <= ~d;
  endtask : access
endmodule : rc_host_model

`default_nettype wire

// File: remote_command_error_queue_bench.sv
// Self-checking bench for the remote command front end and error queue
`timescale 1ns/1ps
`default_nettype none

module remote_command_error_queue_bench;
  import rc_err_pkg::*;
  // ---------------------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------------------
  logic                  ref_clk;
  logic                  rst_n;
  logic [AVS_ADDR_W-1:0] address;
  logic                  rd_req;
  logic                  wr_req;
  logic [AVS_DATA_W-1:0] wdata;
  logic [AVS_DATA_W-1:0] rdata;
  logic                  waitreq;
  hw_evt_t               hw_events;
  logic                  pres;
  op_state_t             op_state;
  logic                  out_active;
  logic                  err_pending;
  logic                  stuck;
  int                    failures;
  int                    tests_run;

  remote_command_error_queue #(.QUEUE_DEPTH(4)) dut_u (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_avs_address(address), .i_avs_read(rd_req),
    .i_avs_write(wr_req), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_hw_events(hw_events), .i_pressure_present(pres),
    .o_op_state(op_state), .o_output_active(out_active), .o_error_pending(err_pending));

  rc_host_model host_u (
    .i_ref_clk(ref_clk), .i_avs_readdata(rdata), .i_avs_waitrequest(waitreq),
    .o_avs_address(address), .o_avs_read(rd_req), .o_avs_write(wr_req),
    .o_avs_writedata(wdata), .o_stuck(stuck));

  always #25 ref_clk = ~ref_clk;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    host_u.access(1'b0, a, d, q);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    host_u.access(1'b1, a, 32'h0, q);
  endtask : rd

  task automatic pop_chk(input err_class_t cls, input logic [7:0] code);
    logic [31:0] q;
    rd(ADDR_POP, q);
    chk(q, {22'h0, cls, code});
  endtask : pop_chk

  task automatic state_case(input logic [3:0] op, input logic [1:0] exp);
    logic [31:0] q;
    wr(ADDR_CMD, {28'h0, op});
    rd(ADDR_STATE, q);
    chk({30'h0, q[1:0]}, {30'h0, exp});
    chk({30'h0, op_state}, {30'h0, exp});
  endtask : state_case

  // One command, its single logged error, then an empty queue
  task automatic err_case(input logic [4:0] m, input logic [16:0] c, input logic [7:0] code,
                          input err_class_t cls);
    wr(ADDR_MODE, {27'h0, m});
    wr(ADDR_CMD, {15'h0, c});
    pop_chk(cls, code);
    pop_chk(CLS_EXE, 8'h00);
  endtask : err_case

  task automatic hw_case(input int idx, input err_class_t cls, input logic [7:0] code);
    @(posedge ref_clk);
    hw_events <= hw_evt_t'(7'h01 << idx);
    @(posedge ref_clk);
    hw_events <= '0;
    pop_chk(cls, code);
    pop_chk(CLS_EXE, 8'h00);
  endtask : hw_case

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic test_states();
    logic [31:0] q;
    pop_chk(CLS_EXE, 8'h00);
    state_case(4'h3, 2'b01);
    state_case(4'h2, 2'b10);
    state_case(4'h3, 2'b10);
    state_case(4'h1, 2'b00);
    state_case(4'h3, 2'b01);
    state_case(4'h1, 2'b00);
    // Output activate then standby, no error in source mode
    wr(ADDR_CMD, 32'h4);
    rd(ADDR_STATE, q);
    chk(q, 32'h4);
    chk({31'h0, out_active}, 32'h1);
    wr(ADDR_CMD, 32'h5);
    rd(ADDR_STATE, q);
    chk(q, 32'h0);
    chk({31'h0, out_active}, 32'h0);
    wr(5'h1c, 32'hffff_ffff);
    rd(5'h1c, q);
    chk(q, 32'h0);
    $display("test_states done");
  endtask : test_states

  task automatic test_cmd_errors();
    err_case(5'h00, 17'h10000, 8'h75, CLS_CME);
    err_case(5'h00, 17'h00006, 8'h6c, CLS_CME);
    err_case(5'h00, 17'h0007f, 8'h65, CLS_CME);
    err_case(5'h00, 17'h005bf, 8'h66, CLS_EXE);
    err_case(5'h00, 17'h0053f, 8'h00, CLS_EXE);
    err_case(5'h00, 17'h0103f, 8'h67, CLS_CME);
    err_case(5'h00, 17'h0203f, 8'h69, CLS_EXE);
    err_case(5'h00, 17'h0403f, 8'h6a, CLS_EXE);
    err_case(5'h01, 17'h00004, 8'h64, CLS_EXE);
    err_case(5'h02, 17'h00005, 8'h64, CLS_EXE);
    err_case(5'h10, 17'h0000d, 8'h68, CLS_EXE);
    err_case(5'h08, 17'h0000e, 8'h68, CLS_EXE);
    err_case(5'h00, 17'h0001a, 8'h6d, CLS_CME);
    err_case(5'h00, 17'h0001b, 8'h6d, CLS_CME);
    err_case(5'h00, 17'h00016, 8'h6e, CLS_CME);
    err_case(5'h00, 17'h00017, 8'h70, CLS_CME);
    err_case(5'h00, 17'h00018, 8'h71, CLS_CME);
    err_case(5'h00, 17'h00019, 8'h72, CLS_CME);
    err_case(5'h00, 17'h08036, 8'h6f, CLS_EXE);
    err_case(5'h00, 17'h0000c, 8'h74, CLS_EXE);
    err_case(5'h00, 17'h0001f, 8'h76, CLS_CME);
    @(posedge ref_clk);
    pres <= 1'b1;
    err_case(5'h00, 17'h0000c, 8'h00, CLS_EXE);
    $display("test_cmd_errors done");
  endtask : test_cmd_errors

  task automatic test_hw_faults();
    hw_case(0, CLS_EXE, 8'h74);
    hw_case(1, CLS_EXE, 8'h78);
    hw_case(2, CLS_EXE, 8'h79);
    hw_case(3, CLS_QYE, 8'h7a);
    hw_case(4, CLS_DDE, 8'h7b);
    hw_case(5, CLS_DDE, 8'h7c);
    hw_case(6, CLS_DDE, 8'h7d);
    $display("test_hw_faults done");
  endtask : test_hw_faults

  // Seven faults at once into a four-deep queue
  task automatic test_overflow();
    logic [31:0] q;
    @(posedge ref_clk);
    hw_events <= hw_evt_t'(7'h7f);
    @(posedge ref_clk);
    hw_events <= '0;
    repeat (12) @(posedge ref_clk);
    rd(ADDR_COUNT, q);
    chk(q, 32'h4);
    chk({31'h0, err_pending}, 32'h1);
    pop_chk(CLS_DDE, 8'h01);
    pop_chk(CLS_EXE, 8'h79);
    pop_chk(CLS_EXE, 8'h78);
    pop_chk(CLS_EXE, 8'h74);
    pop_chk(CLS_EXE, 8'h00);
    chk({31'h0, err_pending}, 32'h0);
    $display("test_overflow done");
  endtask : test_overflow

  // ---------------------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  always @(posedge ref_clk) begin
    if (stuck === 1'b1) begin
      failures++;
      complete_run();
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    complete_run();
  end

  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    hw_events = '0;
    pres = 1'b0;
    failures = 0;
    tests_run = 0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    test_states();
    test_cmd_errors();
    test_hw_faults();
    test_overflow();
    complete_run();
  end
endmodule : remote_command_error_queue_bench

`default_nettype wire
